// file: dv/host_model.sv
`timescale 1ns/100ps
// Serial host stand-in: register requests and address queries
module host_model (
    input  wire logic                       sys_clk,
    input  wire monitor_map_pkg::reg_rsp_t  rsp_q,
    input  wire logic                       rsp_valid_q,
    input  wire logic                       qry_ack_q,
    input  wire logic [7:0]                 qry_addr_q,
    output monitor_map_pkg::reg_req_t       req,
    output logic                            req_valid,
    output logic                            qry_valid,
    output logic [7:0]                      qry_func,
    output logic [7:0]                      qry_sub,
    output logic [7:0]                      qry_payload
);
    initial begin
        req_valid = 1'b0;
        qry_valid = 1'b0;
        req = '0;
        {qry_func, qry_sub, qry_payload} = '0;
    end
    // One request per call; released fields flip so stale data never matches
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [15:0] d, output logic [24:0] r);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= {wr, a, d};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req <= ~req;
        #1 r = {rsp_valid_q, rsp_q};
    endtask : access
    // Address inquiry; framing and check bytes live outside
    task automatic query(input logic [23:0] b, output logic [8:0] r);
        @(posedge sys_clk);
        qry_valid <= 1'b1;
        {qry_func, qry_sub, qry_payload} <= b;
        @(posedge sys_clk);
        qry_valid <= 1'b0;
        {qry_func, qry_sub, qry_payload} <= ~b;
        #1 r = {qry_ack_q, qry_addr_q};
    endtask : query
endmodule : host_model

// file: dv/monitor_status_output_map_bench.sv
`timescale 1ns/100ps
module monitor_status_output_map_bench;
    logic sys_clk = 1'b0, reset_n = 1'b0, di1 = 1'b0, di2 = 1'b0;
    logic rl1, rl2, gnd, tsw, qv, qa, rv, req_valid;
    logic [3:0]  alarm = '0;
    logic [7:0]  qf, qs, qp, qaddr;
    logic [15:0] st;
    logic [24:0] r;
    logic [8:0]  q;
    // Relay selector offsets and their highest legal codes
    logic [15:0] ad [6] = '{16'h0500, 16'h0501, 16'h0502,
                            16'h0510, 16'h0511, 16'h0512};
    logic [15:0] mx [6] = '{16'h5, 16'h6, 16'h2, 16'h5, 16'h6, 16'h2};
    monitor_map_pkg::front_t   front = '0;
    monitor_map_pkg::reg_req_t req;
    monitor_map_pkg::reg_rsp_t rsp;
    int err_total = 0, total_checks = 0;
    always #2 sys_clk = ~sys_clk;
    host_model u_host_model (.sys_clk(sys_clk), .rsp_q(rsp),
        .rsp_valid_q(rv), .qry_ack_q(qa), .qry_addr_q(qaddr), .req(req),
        .req_valid(req_valid), .qry_valid(qv), .qry_func(qf),
        .qry_sub(qs), .qry_payload(qp));
    monitor_status_output_map u_monitor_status_output_map (
        .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req(req), .rsp_q(rsp), .rsp_valid_q(rv), .qry_valid(qv),
        .qry_func(qf), .qry_sub(qs), .qry_payload(qp), .qry_ack_q(qa),
        .qry_addr_q(qaddr), .front(front), .meas_alarm(alarm),
        .digital_input_one(di1), .digital_input_two(di2),
        .ground_switch_q(gnd), .self_test_switch_q(tsw), .status_q(st),
        .relay_one(rl1), .relay_two(rl2));
    ////////////////////////////////////////////////////////////////////
    task automatic check(string n, logic [24:0] s, logic [24:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Sources: 0 pos, 1 neg, 2 bus, 3 temp, 4 input one, 5 input two
    function automatic logic relay_exp(logic [5:0] v, logic [2:0] p,
                                       logic [2:0] s, logic [1:0] c);
        logic a, b;
        a = (p < 3'd6) ? v[p] : 1'b0;
        b = (s == 3'h0) ? a : v[s-3'h1];
        if (c == 2'h2) return ~a;
        return (c == 2'h0) ? (a & b) : (a | b);
    endfunction : relay_exp
    // Front pulses dropped after one cycle, levels kept
    task automatic pulse(logic [6:0] f);
        @(posedge sys_clk);
        front <= f;
        @(posedge sys_clk);
        front <= f & 7'h78;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////
    // Hang guard sized well past the whole sequence
    initial begin
        #40000;
        err_total++;
        report_and_stop();
    end
    initial begin
        logic [15:0] v, p, s, c;
        logic [6:0]  f;
        void'($urandom(98113));
        repeat (5) @(posedge sys_clk);
        check("reset status", st, 25'h0);
        reset_n <= 1'b1;
        // Legal codes kept, one past the top refused and ignored
        for (int i = 0; i < 6; i++) begin
            v = 16'($urandom % (mx[i] + 1));
            u_host_model.access(1'b1, ad[i], v, r);
            check("wr ack", r[24:16], 9'h100);
            u_host_model.access(1'b0, ad[i], 16'h0, r);
            check("rd", r, {9'h100, v});
            u_host_model.access(1'b1, ad[i], mx[i] + 16'h1, r);
            check("bad wr", r[24:16], 9'h103);
            u_host_model.access(1'b0, ad[i], 16'h0, r);
            check("kept", r, {9'h100, v});
        end
        u_host_model.access(1'b0, 16'h0503, 16'h0, r);
        check("unmapped", r, 25'h1020000);
        u_host_model.access(1'b1, 16'h001b, 16'h1, r);
        check("ro status", r[24:16], 9'h103);
        // Address inquiry, wrong sub-code, then a new address
        u_host_model.query(24'hff66a5, q);
        check("query", q, 9'h101);
        u_host_model.query(24'hff67a5, q);
        check("bad query", q, 9'h001);
        v = 16'($urandom % 247 + 1);
        u_host_model.access(1'b1, 16'h0300, v, r);
        u_host_model.query(24'hff66a5, q);
        check("new id", q, {1'b1, v[7:0]});
        // Monitoring and self-test switches
        u_host_model.access(1'b1, 16'h0102, 16'h0012, r);
        check("bad mon", r[24:16], 9'h103);
        u_host_model.access(1'b1, 16'h0102, 16'h0011, r);
        u_host_model.access(1'b1, 16'h0103, 16'h0013, r);
        pulse(7'h01);
        check("switches", {gnd, tsw, st[3:1]}, 5'h1f);
        pulse(7'h06);
        check("passed", st[4], 1'b1);
        pulse(7'h04);
        check("failed", st[4], 1'b0);
        u_host_model.access(1'b1, 16'h0103, 16'h0, r);
        u_host_model.access(1'b1, 16'h0102, 16'h0, r);
        pulse(7'h0);
        check("off", {gnd, tsw, st[3:1]}, 5'h0);
        // Random front levels against the packed status fields
        repeat (20) begin
            f = {4'($urandom), 3'h0};
            pulse(f);
            check("status", st & 16'hffe1,
                  {5'h0, f[6], 2'h0, f[5:3], 5'h0});
        end
        // Random relay setups, alarms and inputs, both outputs
        repeat (40) begin
            p = 16'($urandom % 6);
            s = 16'($urandom % 7);
            c = 16'($urandom % 3);
            v[0] = 1'($urandom % 2);
            u_host_model.access(1'b1, v[0] ? 16'h0510 : 16'h0500, p, r);
            u_host_model.access(1'b1, v[0] ? 16'h0511 : 16'h0501, s, r);
            u_host_model.access(1'b1, v[0] ? 16'h0512 : 16'h0502, c, r);
            @(posedge sys_clk);
            {di2, di1, alarm} <= 6'($urandom);
            repeat (5) @(posedge sys_clk);
            check("relay", v[0] ? rl2 : rl1, relay_exp({di2, di1, alarm},
                  p[2:0], s[2:0], c[1:0]));
        end
        report_and_stop();
    end
endmodule : monitor_status_output_map_bench

// file: hdl/monitor_status_output_map.sv
`timescale 1ns/100ps
// Behaviour
// - Output one combine register takes 0 AND, 1 OR, 2 NOT.
// - Output two primary source: codes 0 to 5, 6 and 7 reserved.
// - Output two secondary source: 0 none, codes 1 to 6, 7 reserved.
// - Output two combine register takes 0 AND, 1 OR, 2 NOT.
// - Query with function ff, sub-code 66, payload a5 returns own slave address.
// - Status bits 10..8 show 000 balanced, 100 unbalanced mode.
// - Status bit 7 set while reversed bus voltage exceeds 100V.
// - Status bit 6 set while negative pole resistance below threshold.
// - Status bit 5 set while positive pole resistance below threshold.
// - Status bit 4 is one only after a passed self-test.
// - Status bit 3 shows self-test circuit on, test switch closed.
// - Status bit 2 shows monitoring on, grounding switch closed.
// - Status bit 1 stays zero until a measurement completes.
// - Writing 17 enables monitoring, 0 disables it.
// - Writing 19 starts the self-test, 0 stops it.
module monitor_status_output_map (
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    input  wire logic                       req_valid,
    input  wire monitor_map_pkg::reg_req_t  req,
    output monitor_map_pkg::reg_rsp_t       rsp_q,
    output logic                            rsp_valid_q,
    input  wire logic                       qry_valid,
    input  wire logic [7:0]                 qry_func,
    input  wire logic [7:0]                 qry_sub,
    input  wire logic [7:0]                 qry_payload,
    output logic                            qry_ack_q,
    output logic [7:0]                      qry_addr_q,
    input  wire monitor_map_pkg::front_t    front,
    input  wire logic [3:0]                 meas_alarm,
    input  wire logic                       digital_input_one,
    input  wire logic                       digital_input_two,
    output logic                            ground_switch_q,
    output logic                            self_test_switch_q,
    output logic [15:0]                     status_q,
    output logic                            relay_one,
    output logic                            relay_two
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // True when the offset names a register of this block
    function automatic logic is_mapped(input logic [15:0] a);
        is_mapped = (a == monitor_map_pkg::ADDR_STATUS)   ||
                    (a == monitor_map_pkg::ADDR_MON_CTRL) ||
                    (a == monitor_map_pkg::ADDR_TST_CTRL) ||
                    (a == monitor_map_pkg::ADDR_SLAVE_ID) ||
                    (a == monitor_map_pkg::ADDR_O1_PRI)   ||
                    (a == monitor_map_pkg::ADDR_O1_SEC)   ||
                    (a == monitor_map_pkg::ADDR_O1_LOGIC) ||
                    (a == monitor_map_pkg::ADDR_O2_PRI)   ||
                    (a == monitor_map_pkg::ADDR_O2_SEC)   ||
                    (a == monitor_map_pkg::ADDR_O2_LOGIC);
    endfunction : is_mapped

    // True when a write value is legal for the addressed register
    function automatic logic value_ok(input logic [15:0] a,
                                      input logic [15:0] v);
        case (a)
            monitor_map_pkg::ADDR_O1_PRI,
            monitor_map_pkg::ADDR_O2_PRI:
                value_ok = (v <= monitor_map_pkg::PRI_MAX);
            monitor_map_pkg::ADDR_O1_SEC,
            monitor_map_pkg::ADDR_O2_SEC:
                value_ok = (v <= monitor_map_pkg::SEC_MAX);
            monitor_map_pkg::ADDR_O1_LOGIC,
            monitor_map_pkg::ADDR_O2_LOGIC:
                value_ok = (v <= monitor_map_pkg::LOGIC_MAX);
            monitor_map_pkg::ADDR_MON_CTRL:
                value_ok = (v == monitor_map_pkg::CTRL_OFF) ||
                           (v == monitor_map_pkg::MON_ON_CODE);
            monitor_map_pkg::ADDR_TST_CTRL:
                value_ok = (v == monitor_map_pkg::CTRL_OFF) ||
                           (v == monitor_map_pkg::TST_ON_CODE);
            monitor_map_pkg::ADDR_SLAVE_ID:
                value_ok = (v >= 16'(monitor_map_pkg::ID_MIN)) &&
                           (v <= 16'(monitor_map_pkg::ID_MAX));
            default:
                value_ok = 1'b0;
        endcase
    endfunction : value_ok

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [2:0]  o1_pri_q;
    logic [2:0]  o1_sec_q;
    logic [1:0]  o1_logic_q;
    logic [2:0]  o2_pri_q;
    logic [2:0]  o2_sec_q;
    logic [1:0]  o2_logic_q;
    logic [7:0]  slave_id_q;
    logic        mon_on_q;
    logic        test_on_q;
    logic        test_pass_q;
    logic        meas_valid_q;
    logic [1:0]  di1_sync_q;
    logic [1:0]  di2_sync_q;

    logic        wr_ok;
    logic        wr_bad;
    logic        mapped;
    logic        wr_en;
    logic [15:0] rd_data;
    logic [15:0] status_d;
    logic [7:0]  exc_d;
    logic        qry_hit;
    logic        mon_on_wr;
    logic        mon_off_wr;
    logic        test_on_wr;
    logic        test_off_wr;
    logic        mon_on_d;
    logic        test_on_d;
    logic        test_pass_d;
    logic        meas_valid_d;
    logic [monitor_map_pkg::NUM_SRC-1:0] alarm_vec;

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    // Writes with bad values or to read-only space change nothing
    assign mapped = is_mapped(req.addr);
    assign wr_ok  = mapped && value_ok(req.addr, req.wdata);
    assign wr_bad = req.write &&
                    (!wr_ok || (req.addr == monitor_map_pkg::ADDR_STATUS));
    assign wr_en  = req_valid && req.write && wr_ok;
    assign exc_d  = !mapped ? monitor_map_pkg::EXC_ADDR  :
                    wr_bad  ? monitor_map_pkg::EXC_VALUE :
                              monitor_map_pkg::EXC_NONE;

    // Control register writes, decoded once
    assign mon_on_wr   = wr_en &&
                         (req.addr == monitor_map_pkg::ADDR_MON_CTRL) &&
                         (req.wdata == monitor_map_pkg::MON_ON_CODE);
    assign mon_off_wr  = wr_en &&
                         (req.addr == monitor_map_pkg::ADDR_MON_CTRL) &&
                         (req.wdata == monitor_map_pkg::CTRL_OFF);
    assign test_on_wr  = wr_en &&
                         (req.addr == monitor_map_pkg::ADDR_TST_CTRL) &&
                         (req.wdata == monitor_map_pkg::TST_ON_CODE);
    assign test_off_wr = wr_en &&
                         (req.addr == monitor_map_pkg::ADDR_TST_CTRL) &&
                         (req.wdata == monitor_map_pkg::CTRL_OFF);

    // Monitoring and self-test switches follow their control codes
    assign mon_on_d  = mon_on_wr  ? 1'b1 :
                       mon_off_wr ? 1'b0 : mon_on_q;
    assign test_on_d = test_on_wr  ? 1'b1 :
                       test_off_wr ? 1'b0 : test_on_q;

    // Result is stale once a new test starts; a passing report wins
    assign test_pass_d = (front.test_done && front.test_pass) ? 1'b1 :
                         (front.test_done || test_on_wr) ? 1'b0 :
                         test_pass_q;

    // Valid only after a completed measurement; set beats the clear
    assign meas_valid_d = (front.meas_done && mon_on_q) ? 1'b1 :
                          mon_off_wr ? 1'b0 : meas_valid_q;

    ////////////////////////////////////////////////////////////////////////
    // Status word assembly

    assign status_d = {
        5'h00,
        front.unbalanced ? monitor_map_pkg::MODE_UNBAL
                         : monitor_map_pkg::MODE_BALANCED,
        front.reverse_hi,
        front.neg_fault,
        front.pos_fault,
        test_pass_q,
        test_on_q,
        mon_on_q,
        meas_valid_q,
        1'b0
    };

    // Read mux; unmapped reads answer zero with an exception
    assign rd_data =
        (req.addr == monitor_map_pkg::ADDR_STATUS)   ? status_q :
        (req.addr == monitor_map_pkg::ADDR_MON_CTRL) ?
            (mon_on_q ? monitor_map_pkg::MON_ON_CODE
                      : monitor_map_pkg::CTRL_OFF) :
        (req.addr == monitor_map_pkg::ADDR_TST_CTRL) ?
            (test_on_q ? monitor_map_pkg::TST_ON_CODE
                       : monitor_map_pkg::CTRL_OFF) :
        (req.addr == monitor_map_pkg::ADDR_SLAVE_ID) ? {8'h00, slave_id_q} :
        (req.addr == monitor_map_pkg::ADDR_O1_PRI)   ? {13'h0000, o1_pri_q} :
        (req.addr == monitor_map_pkg::ADDR_O1_SEC)   ? {13'h0000, o1_sec_q} :
        (req.addr == monitor_map_pkg::ADDR_O1_LOGIC) ? {14'h0000, o1_logic_q} :
        (req.addr == monitor_map_pkg::ADDR_O2_PRI)   ? {13'h0000, o2_pri_q} :
        (req.addr == monitor_map_pkg::ADDR_O2_SEC)   ? {13'h0000, o2_sec_q} :
        (req.addr == monitor_map_pkg::ADDR_O2_LOGIC) ? {14'h0000, o2_logic_q} :
        16'h0000;

    // Checksum bytes are checked by the framing layer, not here
    assign qry_hit = qry_valid &&
                     (qry_func == monitor_map_pkg::QRY_FUNC) &&
                     (qry_sub == monitor_map_pkg::QRY_SUB) &&
                     (qry_payload == monitor_map_pkg::QRY_PAYLOAD);

    ////////////////////////////////////////////////////////////////////////
    // Sequential state

    // Input pins cross into sys_clk through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            di1_sync_q <= 2'b00;
            di2_sync_q <= 2'b00;
        end else begin
            di1_sync_q <= {di1_sync_q[0], digital_input_one};
            di2_sync_q <= {di2_sync_q[0], digital_input_two};
        end
    end

    // Relay configuration and slave address registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            o1_pri_q   <= 3'h0;
            o1_sec_q   <= 3'h0;
            o1_logic_q <= 2'h0;
            o2_pri_q   <= 3'h0;
            o2_sec_q   <= 3'h0;
            o2_logic_q <= 2'h0;
            slave_id_q <= monitor_map_pkg::ID_RESET;
        end else if (wr_en) begin
            case (req.addr)
                monitor_map_pkg::ADDR_O1_PRI:   o1_pri_q   <= req.wdata[2:0];
                monitor_map_pkg::ADDR_O1_SEC:   o1_sec_q   <= req.wdata[2:0];
                monitor_map_pkg::ADDR_O1_LOGIC: begin
                    o1_logic_q <= req.wdata[1:0];
                end
                monitor_map_pkg::ADDR_O2_PRI: begin
                    o2_pri_q   <= req.wdata[2:0];
                end
                monitor_map_pkg::ADDR_O2_SEC: begin
                    o2_sec_q   <= req.wdata[2:0];
                end
                monitor_map_pkg::ADDR_O2_LOGIC: begin
                    o2_logic_q <= req.wdata[1:0];
                end
                monitor_map_pkg::ADDR_SLAVE_ID: slave_id_q <= req.wdata[7:0];
                default: ;
            endcase
        end
    end

    // Control, status and answer registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mon_on_q           <= 1'b0;
            test_on_q          <= 1'b0;
            test_pass_q        <= 1'b0;
            meas_valid_q       <= 1'b0;
            ground_switch_q    <= 1'b0;
            self_test_switch_q <= 1'b0;
            status_q           <= 16'h0000;
            rsp_valid_q        <= 1'b0;
            rsp_q              <= '0;
            qry_ack_q          <= 1'b0;
            qry_addr_q         <= 8'h00;
        end else begin
            mon_on_q           <= mon_on_d;
            test_on_q          <= test_on_d;
            test_pass_q        <= test_pass_d;
            meas_valid_q       <= meas_valid_d;
            ground_switch_q    <= mon_on_d;
            self_test_switch_q <= test_on_d;
            status_q           <= status_d;
            rsp_valid_q        <= req_valid;
            rsp_q              <= '{exc: exc_d, rdata: rd_data};
            qry_ack_q          <= qry_hit;
            qry_addr_q         <= qry_hit ? slave_id_q : qry_addr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Relay outputs

    assign alarm_vec = {di2_sync_q[1], di1_sync_q[1], meas_alarm};

    relay_combine u_relay_one (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .alarm_vec (alarm_vec),
        .pri_sel   (o1_pri_q),
        .sec_sel   (o1_sec_q),
        .comb_sel  (o1_logic_q),
        .relay_q   (relay_one)
    );

    relay_combine u_relay_two (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .alarm_vec (alarm_vec),
        .pri_sel   (o2_pri_q),
        .sec_sel   (o2_sec_q),
        .comb_sel  (o2_logic_q),
        .relay_q   (relay_two)
    );

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic_range_a: assert property (o1_logic_q <= 2'h2 && o2_logic_q <= 2'h2)
        else $error("combine code out of range");
    pri_range_a: assert property (o2_pri_q <= 3'h5)
        else $error("primary source reserved");
    sec_range_a: assert property (o2_sec_q <= 3'h6)
        else $error("secondary source reserved");
    logic_write_a: assert property (req_valid && req.write &&
            req.addr == monitor_map_pkg::ADDR_O2_LOGIC && req.wdata > 16'h2
            |=> $stable(o2_logic_q) && rsp_q.exc == monitor_map_pkg::EXC_VALUE)
        else $error("bad combine write accepted");
    query_ack_a: assert property (qry_hit |=> qry_ack_q &&
            qry_addr_q == $past(slave_id_q))
        else $error("query not answered with address");
    mode_bits_a: assert property (status_q[10:8] == 3'h0 ||
            status_q[10:8] == 3'h4)
        else $error("mode field illegal");
    fault_bits_a: assert property (##1 status_q[7:5] ==
            $past({front.reverse_hi, front.neg_fault, front.pos_fault}))
        else $error("fault bits lag front end");
    pass_clear_a: assert property (front.test_done && !front.test_pass
            |=> ##1 !status_q[4])
        else $error("failed test reads passed");
    mon_on_a: assert property (mon_on_wr |=> ground_switch_q ##1 status_q[2])
        else $error("monitor enable not reflected");
    test_on_a: assert property (test_on_wr |=> self_test_switch_q
            ##1 status_q[3])
        else $error("self-test start not reflected");
    null_bits_a: assert property (status_q[15:11] == 5'h00 && !status_q[0])
        else $error("null status bits set");
    valid_off_a: assert property (mon_off_wr && !front.meas_done
            |=> ##1 !status_q[1])
        else $error("valid bit survives disable");

    // Front end levels must reach the status word one cycle later, a completed measurement two cycles later
    unbal_mode_a: assert property (front.unbalanced |=>
            status_q[10:8] == monitor_map_pkg::MODE_UNBAL)
        else $error("unbalanced mode not shown");
    neg_fault_a: assert property (front.neg_fault |=> status_q[6])
        else $error("negative fault not shown");
    pos_fault_a: assert property (front.pos_fault |=> status_q[5])
        else $error("positive fault not shown");
    valid_set_a: assert property (front.meas_done && mon_on_q
            |=> ##1 status_q[1])
        else $error("completed measurement not valid");

endmodule : monitor_status_output_map

// file: hdl/relay_combine.sv
`timescale 1ns/100ps

// One relay output: selects two alarm sources and combines them
module relay_combine (
    input  wire logic                                 sys_clk,
    input  wire logic                                 reset_n,
    input  wire logic [monitor_map_pkg::NUM_SRC-1:0]  alarm_vec,
    input  wire logic [2:0]                           pri_sel,
    input  wire logic [2:0]                           sec_sel,
    input  wire logic [1:0]                           comb_sel,
    output logic                                      relay_q
);

    logic pri_alarm;
    logic sec_alarm;
    logic sec_used;
    logic relay_d;

    // Reserved codes select nothing, so they read as an inactive alarm
    assign pri_alarm = (pri_sel < 3'(monitor_map_pkg::NUM_SRC))
                       ? alarm_vec[pri_sel] : 1'b0;
    assign sec_used  = (sec_sel != 3'h0) &&
                       (sec_sel <= 3'(monitor_map_pkg::NUM_SRC));
    assign sec_alarm = sec_used ? alarm_vec[sec_sel - 3'h1] : 1'b0;

    // With no linked source, AND and OR both pass the mapped alarm
    assign relay_d =
        (comb_sel == monitor_map_pkg::COMB_NOT) ? ~pri_alarm :
        (comb_sel == monitor_map_pkg::COMB_OR)  ? (pri_alarm | sec_alarm) :
        sec_used ? (pri_alarm & sec_alarm) : pri_alarm;

    // Registered so the relay pin never sees decode glitches
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) relay_q <= 1'b0;
        else          relay_q <= relay_d;
    end

endmodule : relay_combine

// file: pkg/monitor_map_pkg.sv
package monitor_map_pkg;

    // Register offsets as seen over the serial register link
    localparam logic [15:0] ADDR_STATUS   = 16'h001b;
    localparam logic [15:0] ADDR_MON_CTRL = 16'h0102;
    localparam logic [15:0] ADDR_TST_CTRL = 16'h0103;
    localparam logic [15:0] ADDR_SLAVE_ID = 16'h0300;
    localparam logic [15:0] ADDR_O1_PRI   = 16'h0500;
    localparam logic [15:0] ADDR_O1_SEC   = 16'h0501;
    localparam logic [15:0] ADDR_O1_LOGIC = 16'h0502;
    localparam logic [15:0] ADDR_O2_PRI   = 16'h0510;
    localparam logic [15:0] ADDR_O2_SEC   = 16'h0511;
    localparam logic [15:0] ADDR_O2_LOGIC = 16'h0512;

    // Control codes
    localparam logic [15:0] CTRL_OFF      = 16'h0000;
    localparam logic [15:0] MON_ON_CODE   = 16'h0011;
    localparam logic [15:0] TST_ON_CODE   = 16'h0013;

    // Slave address query frame
    localparam logic [7:0]  QRY_FUNC      = 8'hff;
    localparam logic [7:0]  QRY_SUB       = 8'h66;
    localparam logic [7:0]  QRY_PAYLOAD   = 8'ha5;

    // Slave address range and value after reset
    localparam logic [7:0]  ID_RESET      = 8'h01;
    localparam logic [7:0]  ID_MIN        = 8'h01;
    localparam logic [7:0]  ID_MAX        = 8'hf7;

    // Highest legal selector codes
    localparam logic [15:0] PRI_MAX       = 16'h0005;
    localparam logic [15:0] SEC_MAX       = 16'h0006;
    localparam logic [15:0] LOGIC_MAX     = 16'h0002;

    // Status word field positions
    localparam int          ST_MODE_LSB   = 8;
    localparam int          ST_REVERSE    = 7;
    localparam int          ST_NEG_FAULT  = 6;
    localparam int          ST_POS_FAULT  = 5;
    localparam int          ST_TEST_PASS  = 4;
    localparam int          ST_TEST_ON    = 3;
    localparam int          ST_MON_ON     = 2;
    localparam int          ST_VALID      = 1;
    localparam logic [2:0]  MODE_BALANCED = 3'h0;
    localparam logic [2:0]  MODE_UNBAL    = 3'h4;

    // Exception codes returned with an answer
    localparam logic [7:0]  EXC_NONE      = 8'h00;
    localparam logic [7:0]  EXC_ADDR      = 8'h02;
    localparam logic [7:0]  EXC_VALUE     = 8'h03;

    localparam int          NUM_SRC       = 6;

    typedef enum logic [1:0] {
        COMB_AND = 2'b00,
        COMB_OR  = 2'b01,
        COMB_NOT = 2'b10
    } combine_t;

    typedef struct packed {
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0]  exc;
        logic [15:0] rdata;
    } reg_rsp_t;

    // Levels and pulses from the measurement front end
    typedef struct packed {
        logic unbalanced;
        logic reverse_hi;
        logic neg_fault;
        logic pos_fault;
        logic test_done;
        logic test_pass;
        logic meas_done;
    } front_t;

endpackage : monitor_map_pkg
